/* hw/sbi_defs.vh */
// constants for the sensor bus init and command decode block
// assumes a 10 mhz core clock; included by bare name
`ifndef SBI_DEFS_VH
`define SBI_DEFS_VH

// command codes
`define SBI_CMD_INIT 4'h0
`define SBI_CMD_STATUS 4'h1
`define SBI_CMD_ACCEL 4'h2
`define SBI_CMD_ID 4'h4
`define SBI_CMD_CLEAR 4'h7
`define SBI_CMD_NVM 4'h9
`define SBI_CMD_FORMAT 4'ha
`define SBI_CMD_REGRD 4'hb
`define SBI_CMD_ST_OFF 4'hc
`define SBI_CMD_ST_ON 4'hd

// init data byte fields
`define SBI_INIT_OTP_BIT 7
`define SBI_INIT_SW_BIT 6
`define SBI_INIT_PAGE_HI 5
`define SBI_INIT_PAGE_LO 4
`define SBI_INIT_ID_HI 3
`define SBI_INIT_ID_LO 0

// long-only data byte fields
`define SBI_NVM_WR_HI 7
`define SBI_NVM_WR_LO 4
`define SBI_NVM_RD_HI 3
`define SBI_NVM_RD_LO 0
`define SBI_FMT_RW_BIT 7
`define SBI_FMT_SEL_HI 6
`define SBI_FMT_SEL_LO 4
`define SBI_FMT_VAL_HI 3
`define SBI_FMT_VAL_LO 0
`define SBI_REG_ZERO_HI 7
`define SBI_REG_ZERO_LO 4
`define SBI_REG_IDX_HI 3
`define SBI_REG_IDX_LO 0

// reset values
`define SBI_RST_NODE_ID 4'h0
`define SBI_RST_STARTUP 1'b1
`define SBI_RST_SELFTEST 1'b0

// timing, times in us, counts derived at the clock rate
`define SBI_CLK_MHZ 10
`define SBI_T_LINK_INIT_US 100
`define SBI_T_DSP_INIT_US 400
`define SBI_LINK_INIT_CYC (`SBI_T_LINK_INIT_US * `SBI_CLK_MHZ)
`define SBI_DSP_INIT_CYC (`SBI_T_DSP_INIT_US * `SBI_CLK_MHZ)

`endif

/* hw/sbi_cmd_dec.v */
// command code decoder: implemented codes and permitted frame formats
// assumes the frame fields come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "sbi_defs.vh"

module sbi_cmd_dec (
   input wire [3:0] cmd,
   input wire is_long,
   input wire is_enh,
   output reg impl,
   output reg fmt_ok
);

   always @* begin
      impl = 1'b1;
      fmt_ok = 1'b0;
      case (cmd)
         `SBI_CMD_INIT: begin
            fmt_ok = is_long & ~is_enh;
         end
         `SBI_CMD_STATUS, `SBI_CMD_ACCEL, `SBI_CMD_ID, `SBI_CMD_CLEAR,
         `SBI_CMD_ST_OFF, `SBI_CMD_ST_ON: begin
            fmt_ok = 1'b1;
         end
         `SBI_CMD_NVM, `SBI_CMD_FORMAT, `SBI_CMD_REGRD: begin
            fmt_ok = is_long;
         end
         default: begin
            impl = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

/* hw/sbi_seq.v */
// start-up sequencer: fuse mirror, link-ready and dsp-ready delays
// assumes restart is a level from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module sbi_seq #(
   parameter CNT_W = 16,
   parameter [CNT_W-1:0] LINK_CYC = 16'h03e8,
   parameter [CNT_W-1:0] DSP_CYC = 16'h0fa0
) (
   input wire clock,
   input wire resetn,
   input wire restart,
   input wire fuse_done,
   output reg fuse_start_r,
   output reg link_ready_r,
   output reg dsp_ready_r
);

   localparam [3:0] S_FUSE = 4'b0001;
   localparam [3:0] S_LINK = 4'b0010;
   localparam [3:0] S_DSP = 4'b0100;
   localparam [3:0] S_RUN = 4'b1000;

   reg [3:0] state_r;
   reg [CNT_W-1:0] cnt_r;
   reg armed_r;

   // both delays count from the start of the sequence
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_FUSE;
         cnt_r <= {CNT_W{1'b0}};
         armed_r <= 1'b1;
         fuse_start_r <= 1'b0;
         link_ready_r <= 1'b0;
         dsp_ready_r <= 1'b0;
      end else if (restart) begin
         state_r <= S_FUSE;
         cnt_r <= {CNT_W{1'b0}};
         armed_r <= 1'b1;
         fuse_start_r <= 1'b0;
         link_ready_r <= 1'b0;
         dsp_ready_r <= 1'b0;
      end else begin
         fuse_start_r <= armed_r;
         armed_r <= 1'b0;
         if (cnt_r != {CNT_W{1'b1}})
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         case (state_r)
            S_FUSE: begin
               if (fuse_done && !armed_r && !fuse_start_r)
                  state_r <= S_LINK;
            end
            S_LINK: begin
               if (cnt_r >= LINK_CYC) begin
                  state_r <= S_DSP;
                  link_ready_r <= 1'b1;
               end
            end
            S_DSP: begin
               if (cnt_r >= DSP_CYC) begin
                  state_r <= S_RUN;
                  dsp_ready_r <= 1'b1;
               end
            end
            S_RUN: begin
               state_r <= S_RUN;
            end
            default: begin
               state_r <= S_FUSE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* hw/sbi_init_cmd.v */
// satellite sensor bus node: start-up control and command decode
// assumes a link layer on the same clock that hands over whole frames
// with crc checked, and a fuse mirror engine with start/done handshake
`timescale 1ns/10ps
`default_nettype none
`include "sbi_defs.vh"

module sbi_init_cmd #(
   parameter CNT_W = 16,
   parameter LINK_CYC = `SBI_LINK_INIT_CYC,
   parameter DSP_CYC = `SBI_DSP_INIT_CYC
) (
   input wire clock,
   input wire resetn,
   input wire uv_reset_n,
   input wire fuse_copy_done,
   input wire preprog_valid,
   input wire [3:0] preprog_id,
   input wire frame_start,
   input wire frame_valid,
   input wire frame_long,
   input wire frame_enh,
   input wire frame_crc_ok,
   input wire [3:0] frame_cmd,
   input wire [3:0] frame_addr,
   input wire [7:0] frame_data,
   output reg fuse_copy_start,
   output reg startup_flag,
   output reg selftest_active_flag,
   output reg link_ready,
   output reg accel_valid,
   output reg initialized,
   output reg [3:0] node_id,
   output reg otp_write_permit,
   output reg chain_switch_close,
   output reg [1:0] page_sel,
   output reg resp_valid,
   output reg [3:0] resp_cmd,
   output reg resp_accel_zero,
   output reg resp_accel_invalid,
   output reg nvm_req,
   output reg [3:0] nvm_write_slot,
   output reg [3:0] nvm_read_slot,
   output reg format_req,
   output reg format_write,
   output reg [2:0] format_field_sel,
   output reg [3:0] format_value,
   output reg reg_read_req,
   output reg [3:0] reg_index,
   output reg status_req,
   output reg id_req
);

   // under-voltage pin, two flops before use
   reg uv_meta_r;
   reg uv_sync_r;
   reg clear_go_r;
   wire restart;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         uv_meta_r <= 1'b1;
         uv_sync_r <= 1'b1;
      end else begin
         uv_meta_r <= uv_reset_n;
         uv_sync_r <= uv_meta_r;
      end
   end

   // clear acts one cycle late so its own frame finishes first
   assign restart = ~uv_sync_r | clear_go_r;

   wire fuse_start_w;
   wire link_ready_w;
   wire dsp_ready_w;

   sbi_seq #(
      .CNT_W(CNT_W),
      .LINK_CYC(LINK_CYC[CNT_W-1:0]),
      .DSP_CYC(DSP_CYC[CNT_W-1:0])
   ) u_seq (
      .clock(clock),
      .resetn(resetn),
      .restart(restart),
      .fuse_done(fuse_copy_done),
      .fuse_start_r(fuse_start_w),
      .link_ready_r(link_ready_w),
      .dsp_ready_r(dsp_ready_w)
   );

   wire impl_w;
   wire fmt_ok_w;

   sbi_cmd_dec u_dec (
      .cmd(frame_cmd),
      .is_long(frame_long),
      .is_enh(frame_enh),
      .impl(impl_w),
      .fmt_ok(fmt_ok_w)
   );

   // a frame counts only once the link side is up and no restart is pending
   wire frame_ok = frame_valid & link_ready_w & ~restart & frame_crc_ok;
   wire cmd_ok = frame_ok & impl_w & fmt_ok_w;
   wire is_init = (frame_cmd == `SBI_CMD_INIT);
   wire [3:0] init_id = frame_data[`SBI_INIT_ID_HI:`SBI_INIT_ID_LO];

   // pre-programmed parts must see their own id twice; blank parts expect address zero
   wire init_addr_ok = preprog_valid ?
      ((frame_addr == preprog_id) && (init_id == preprog_id)) : (frame_addr == 4'h0);
   // a failed address check leaves the node silent and unassigned
   wire take_init = cmd_ok & is_init & ~initialized & init_addr_ok;
   wire take_cmd = cmd_ok & ~is_init & initialized & (frame_addr == node_id);
   wire regrd_ok = (frame_data[`SBI_REG_ZERO_HI:`SBI_REG_ZERO_LO] == 4'h0);

   // answer held back until the next transfer starts
   reg pend_r;
   reg [3:0] pend_cmd_r;
   reg pend_zero_r;
   reg pend_inval_r;
   reg pend_nxt;

   always @* begin
      pend_nxt = 1'b0;
      if (take_init)
         pend_nxt = 1'b1;
      // clear restarts the node, so it never answers
      else if (take_cmd && frame_cmd != `SBI_CMD_CLEAR)
         pend_nxt = (frame_cmd != `SBI_CMD_REGRD) | regrd_ok;
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pend_r <= 1'b0;
         pend_cmd_r <= 4'h0;
         pend_zero_r <= 1'b0;
         pend_inval_r <= 1'b0;
         resp_valid <= 1'b0;
         resp_cmd <= 4'h0;
         resp_accel_zero <= 1'b0;
         resp_accel_invalid <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         if (restart) begin
            pend_r <= 1'b0;
         end else begin
            if (frame_start) begin
               resp_valid <= pend_r;
               pend_r <= 1'b0;
               // fields move only with an answer, so they stand until the next one
               if (pend_r) begin
                  resp_cmd <= pend_cmd_r;
                  resp_accel_zero <= pend_zero_r;
                  resp_accel_invalid <= pend_inval_r;
               end
            end
            // a new command after the start of its own transfer wins the slot
            if (pend_nxt) begin
               pend_r <= 1'b1;
               pend_cmd_r <= frame_cmd;
               pend_zero_r <= (frame_cmd == `SBI_CMD_ACCEL) & ~frame_long & ~dsp_ready_w;
               pend_inval_r <= (frame_cmd == `SBI_CMD_ACCEL) & frame_long & ~dsp_ready_w;
            end
         end
      end
   end

   // start-up flags and node configuration
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         startup_flag <= `SBI_RST_STARTUP;
         selftest_active_flag <= `SBI_RST_SELFTEST;
         link_ready <= 1'b0;
         accel_valid <= 1'b0;
         fuse_copy_start <= 1'b0;
         clear_go_r <= 1'b0;
         initialized <= 1'b0;
         node_id <= `SBI_RST_NODE_ID;
         otp_write_permit <= 1'b0;
         chain_switch_close <= 1'b0;
         page_sel <= 2'b00;
      end else begin
         clear_go_r <= 1'b0;
         fuse_copy_start <= fuse_start_w;
         // restart wins over anything taken in the same cycle
         link_ready <= link_ready_w & ~restart;
         accel_valid <= dsp_ready_w & ~restart;
         // startup stays up until the processing side is ready
         startup_flag <= ~dsp_ready_w | restart;
         if (restart) begin
            // clear acts like a reset of the start-up flags and node configuration other than node_id, which keeps its value
            startup_flag <= 1'b1;
            selftest_active_flag <= 1'b0;
            initialized <= 1'b0;
            otp_write_permit <= 1'b0;
            chain_switch_close <= 1'b0;
            page_sel <= 2'b00;
         end else if (take_init) begin
            initialized <= 1'b1;
            node_id <= init_id;
            otp_write_permit <= frame_data[`SBI_INIT_OTP_BIT];
            chain_switch_close <= frame_data[`SBI_INIT_SW_BIT];
            page_sel <= frame_data[`SBI_INIT_PAGE_HI:`SBI_INIT_PAGE_LO];
         end else if (take_cmd) begin
            case (frame_cmd)
               `SBI_CMD_CLEAR: begin
                  clear_go_r <= 1'b1;
               end
               `SBI_CMD_ST_ON: begin
                  // self-test cannot be raised until start-up has finished
                  selftest_active_flag <= dsp_ready_w;
               end
               `SBI_CMD_ST_OFF: begin
                  selftest_active_flag <= 1'b0;
               end
               default: begin
                  selftest_active_flag <= selftest_active_flag & dsp_ready_w;
               end
            endcase
         end else if (!dsp_ready_w) begin
            // self-test is held off for the whole start-up
            selftest_active_flag <= 1'b0;
         end
      end
   end

   // one-cycle requests to the rest of the node, all done in one cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nvm_req <= 1'b0;
         nvm_write_slot <= 4'h0;
         nvm_read_slot <= 4'h0;
         format_req <= 1'b0;
         format_write <= 1'b0;
         format_field_sel <= 3'b000;
         format_value <= 4'h0;
         reg_read_req <= 1'b0;
         reg_index <= 4'h0;
         status_req <= 1'b0;
         id_req <= 1'b0;
      end else begin
         nvm_req <= 1'b0;
         format_req <= 1'b0;
         reg_read_req <= 1'b0;
         status_req <= 1'b0;
         id_req <= 1'b0;
         // data fields are kept so the far side may read them late
         if (take_cmd) begin
            case (frame_cmd)
               `SBI_CMD_NVM: begin
                  nvm_req <= 1'b1;
                  nvm_write_slot <= frame_data[`SBI_NVM_WR_HI:`SBI_NVM_WR_LO];
                  nvm_read_slot <= frame_data[`SBI_NVM_RD_HI:`SBI_NVM_RD_LO];
               end
               `SBI_CMD_FORMAT: begin
                  format_req <= 1'b1;
                  format_write <= frame_data[`SBI_FMT_RW_BIT];
                  format_field_sel <= frame_data[`SBI_FMT_SEL_HI:`SBI_FMT_SEL_LO];
                  format_value <= frame_data[`SBI_FMT_VAL_HI:`SBI_FMT_VAL_LO];
               end
               `SBI_CMD_REGRD: begin
                  // a non-zero upper nibble is an illegal frame, so drop it
                  reg_read_req <= regrd_ok;
                  if (regrd_ok) begin
                     reg_index <= frame_data[`SBI_REG_IDX_HI:`SBI_REG_IDX_LO];
                  end
               end
               `SBI_CMD_STATUS: begin
                  status_req <= 1'b1;
               end
               `SBI_CMD_ID: begin
                  id_req <= 1'b1;
               end
               default: begin
                  id_req <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* dv/sbi_master_model.sv */
// bus master and fuse mirror engine model driving whole frames
// assumes the node samples frame fields on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module sbi_master_model (
   input wire logic clock,
   input wire logic fuse_copy_start,
   output var logic fuse_copy_done,
   output var logic frame_start,
   output var logic frame_valid,
   output var logic frame_long,
   output var logic frame_enh,
   output var logic frame_crc_ok,
   output var logic [3:0] frame_cmd,
   output var logic [3:0] frame_addr,
   output var logic [7:0] frame_data
);
   logic [2:0] copy_sh = 3'h0;
   initial begin
      {frame_start, frame_valid} = 2'h0;
      {frame_long, frame_enh, frame_crc_ok, frame_cmd, frame_addr, frame_data} = 19'h0;
   end
   // slow engine: copy ends four cycles after its start
   always @(posedge clock) begin
      copy_sh <= {copy_sh[1:0], fuse_copy_start};
      fuse_copy_done <= copy_sh[2];
   end
   task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
      input logic lng, input logic enh, input logic crc);
      @(posedge clock);
      frame_valid <= 1'b1;
      {frame_long, frame_enh, frame_crc_ok, frame_cmd, frame_addr, frame_data} <=
         {lng, enh, crc, c, a, d};
      @(posedge clock);
      frame_valid <= 1'b0;
      frame_start <= 1'b1;
      // fields are stale outside a frame, so show their inverse
      {frame_long, frame_enh, frame_crc_ok, frame_cmd, frame_addr, frame_data} <=
         ~{lng, enh, crc, c, a, d};
      @(posedge clock);
      frame_start <= 1'b0;
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

/* dv/sbi_init_cmd_chk.sv */
// timing checks on the start-up and command decode node
// assumes one clock and the asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module sbi_init_cmd_chk (
   input wire logic clock,
   input wire logic resetn,
   input wire logic frame_start,
   input wire logic frame_valid,
   input wire logic frame_long,
   input wire logic frame_enh,
   input wire logic frame_crc_ok,
   input wire logic [3:0] frame_cmd,
   input wire logic fuse_copy_start,
   input wire logic startup_flag,
   input wire logic selftest_active_flag,
   input wire logic link_ready,
   input wire logic accel_valid,
   input wire logic initialized,
   input wire logic resp_valid,
   input wire logic nvm_req,
   input wire logic format_req,
   input wire logic reg_read_req,
   input wire logic status_req,
   input wire logic id_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   wire logic any_req = nvm_req | format_req | reg_read_req | status_req | id_req;
   a_startup_clears: assert property (accel_valid |-> !startup_flag)
      else $error("startup flag high with data valid");
   a_resp_slot: assert property (resp_valid |-> $past(frame_start))
      else $error("answer outside the next transfer");
   a_copy_quiet: assert property (fuse_copy_start |-> startup_flag &&
      !selftest_active_flag && !link_ready) else $error("flags wrong while mirroring");
   a_no_early_resp: assert property (!link_ready && !$past(link_ready) |-> !resp_valid)
      else $error("answer before link ready");
   a_crc_silent: assert property (frame_valid && !frame_crc_ok |=> !any_req)
      else $error("request from a bad crc frame");
   a_code_silent: assert property (frame_valid &&
      frame_cmd inside {4'h3, 4'h5, 4'h6, 4'h8, 4'he, 4'hf} |=> !any_req)
      else $error("request from unused code");
   a_long_only: assert property (frame_valid && !frame_long &&
      frame_cmd inside {4'h9, 4'ha, 4'hb} |=> !any_req) else $error("long-only code taken short");
   a_init_format: assert property ($rose(initialized) |-> $past(frame_valid) &&
      !$past(frame_enh) && $past(frame_long) && $past(frame_cmd) == 4'h0)
      else $error("bad init taken");
   a_before_init: assert property (!initialized && frame_valid |=> !any_req)
      else $error("command taken before init");
   a_link_flags: assert property ($rose(link_ready) |-> startup_flag &&
      !selftest_active_flag) else $error("flags wrong at link ready");
   a_selftest_ready: assert property ($rose(selftest_active_flag) |-> accel_valid)
      else $error("self-test set before processing ready");
endmodule
bind sbi_init_cmd sbi_init_cmd_chk sbi_init_cmd_chk_i (.clock, .resetn, .frame_start,
   .frame_valid, .frame_long, .frame_enh, .frame_crc_ok, .frame_cmd, .fuse_copy_start,
   .startup_flag, .selftest_active_flag, .link_ready, .accel_valid, .initialized, .resp_valid,
   .nvm_req, .format_req, .reg_read_req, .status_req, .id_req);
`default_nettype wire

/* dv/sbi_init_cmd_test.sv */
// self-checking bench for the start-up and command decode node
// assumes short start-up delays so the run stays brief
`timescale 1ns/10ps
`default_nettype none
module sbi_init_cmd_test;
   localparam int LINK = 20;
   localparam int DSP = 60;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic uv_reset_n = 1'b1;
   logic preprog_valid = 1'b0;
   logic [3:0] preprog_id = 4'h0;
   wire logic fuse_copy_done, frame_start, frame_valid, frame_long, frame_enh, frame_crc_ok;
   wire logic [3:0] frame_cmd, frame_addr, node_id, resp_cmd, nvm_write_slot, nvm_read_slot;
   wire logic [3:0] format_value, reg_index;
   wire logic [7:0] frame_data;
   wire logic [2:0] format_field_sel;
   wire logic [1:0] page_sel;
   wire logic fuse_copy_start, startup_flag, selftest_active_flag, link_ready, accel_valid;
   wire logic initialized, otp_write_permit, chain_switch_close, resp_valid, resp_accel_zero;
   wire logic resp_accel_invalid, nvm_req, format_req, format_write, reg_read_req;
   wire logic status_req, id_req;
   int errors = 0;
   int n_tests = 0;
   logic [5:0] exp_q[$];
   logic [3:0] node;
   logic [7:0] d;
   logic [3:0] idx;
   logic [19:0] req_cnt = 20'h0;
   sbi_init_cmd #(.LINK_CYC(LINK), .DSP_CYC(DSP)) sbi_init_cmd_i (.*);
   sbi_master_model sbi_master_model_i (.*);
   always #50 clock = ~clock;
   task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic conclude;
      chk("answers left", 20'h0, 20'(exp_q.size()));
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // z marks an acceleration read before processing is ready
   task automatic xfer(input logic [3:0] c, input logic [7:0] dd, input logic lng,
      input logic enh, input logic crc, input logic ok, input logic z);
      if (ok) exp_q.push_back({c, z & ~lng, z & lng});
      sbi_master_model_i.send(c, node, dd, lng, enh, crc);
   endtask
   task automatic wait_link;
      for (int i = 0; i < LINK + 20 && link_ready !== 1'b1; i++) @(posedge clock);
      @(negedge clock);
      chk("link", 12'h1, link_ready);
   endtask
   always @(posedge clock) begin
      if (resetn === 1'b1)
         req_cnt <= req_cnt + {3'h0, nvm_req, 3'h0, format_req, 3'h0, reg_read_req,
            3'h0, status_req, 3'h0, id_req};
      if (resp_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("extra answer", 12'h0, 12'h1);
         else chk("answer", exp_q.pop_front(), {resp_cmd, resp_accel_zero, resp_accel_invalid});
      end
   end
   initial begin
      repeat (3000) @(posedge clock);
      errors++;
      conclude();
   end
   initial begin
      void'($urandom(32'h3882c8e5));
      node = 4'h0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(negedge clock);
      chk("mirror flags", 12'h4, {startup_flag, selftest_active_flag, link_ready});
      repeat (LINK - 3) @(negedge clock);
      chk("link early", 12'h0, link_ready);
      wait_link();
      chk("startup", 12'h1, startup_flag);
      d = 8'($urandom);
      xfer(4'h1, d, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      xfer(4'h0, d, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      xfer(4'h0, d, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      xfer(4'h0, d, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      chk("init", {1'b1, d}, {initialized, otp_write_permit, chain_switch_close, page_sel, node_id});
      node = d[3:0];
      xfer(4'h2, d, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      xfer(4'h2, d, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      xfer(4'hd, d, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      chk("early self-test", 12'h0, selftest_active_flag);
      for (int i = 0; i < DSP && accel_valid !== 1'b1; i++) @(posedge clock);
      @(negedge clock);
      chk("ready flags", 12'h1, {startup_flag, accel_valid});
      for (int c = 1; c < 16; c++) if (c != 7) begin
         d = 8'($urandom);
         if (c == 11) d[7:4] = 4'h0;
         xfer(4'(c), d, 1'b0, 1'b1, 1'b1, !(c inside {3, 5, 6, 8, 9, 10, 11, 14, 15}), 1'b0);
         xfer(4'(c), d, 1'b1, c[0], 1'b1, !(c inside {3, 5, 6, 8, 14, 15}), 1'b0);
         xfer(4'(c), ~d, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         if (c == 9) chk("nvm", d, {nvm_write_slot, nvm_read_slot});
         if (c == 10) chk("format", d, {format_write, format_field_sel, format_value});
         if (c == 11) idx = d[3:0];
         if (c == 11) chk("index", d[3:0], reg_index);
         if (c == 12) chk("self-test off", 12'h0, selftest_active_flag);
      end
      chk("self-test on", 12'h1, selftest_active_flag);
      xfer(4'hb, {4'h3, ~idx}, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      chk("index kept", idx, reg_index);
      xfer(4'h0, d, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      xfer(4'h7, d, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      chk("clear", 12'h8, {startup_flag, selftest_active_flag, initialized, accel_valid});
      @(posedge clock);
      preprog_valid <= 1'b1;
      preprog_id <= 4'h5;
      node = 4'h5;
      wait_link();
      xfer(4'h0, 8'h96, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      xfer(4'h0, 8'h95, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      chk("preset init", 12'h195, {initialized, otp_write_permit, chain_switch_close, page_sel, node_id});
      @(posedge clock);
      uv_reset_n <= 1'b0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      chk("uv restart", 12'h4, {startup_flag, link_ready, initialized});
      @(posedge clock);
      uv_reset_n <= 1'b1;
      wait_link();
      chk("requests", 20'h11122, req_cnt);
      conclude();
   end
endmodule
`default_nettype wire
